// [logic/mte_pkg.sv]
// shared constants and types for the motion trippoint evaluator
package mte_pkg;

    // number of axes served by one evaluator
    localparam int unsigned MTE_AXES          = 4;
    // width of the axis select field
    localparam int unsigned MTE_AXIS_W        = 2;
    // controller clock rate in hertz
    localparam int unsigned MTE_CLK_HZ        = 25000000;
    // evaluation period in milliseconds
    localparam int unsigned MTE_SAMPLE_MS     = 2;
    // clock cycles in one millisecond
    localparam int unsigned MTE_MS_CYCLES     = MTE_CLK_HZ / 1000;
    // clock cycles in one evaluation period
    localparam int unsigned MTE_SAMPLE_CYCLES = MTE_MS_CYCLES * MTE_SAMPLE_MS;
    // width of the divider counters
    localparam int unsigned MTE_DIV_W         = 16;
    // position in the second status word of the at-slew-speed flag
    localparam int unsigned MTE_SLEW_BIT      = 5;
    // width of one axis status word
    localparam int unsigned MTE_STAT_W        = 8;
    // reset value of the status words
    localparam logic [7:0]  MTE_STAT_RST      = 8'h00;
    // mask that keeps a relative distance inside 0 .. 2147483647
    localparam logic [31:0] MTE_DIST_MASK     = 32'h7fffffff;
    // time operand that only takes a new reference
    localparam logic [31:0] MTE_TIME_ZERO     = 32'h00000000;

    // trippoint kinds issued by the sequencer
    typedef enum logic [1:0] {
        MTE_OP_ABS,      // wait_absolute_position
        MTE_OP_REL,      // wait_relative_distance
        MTE_OP_SPEED,    // wait_at_speed
        MTE_OP_TIME      // wait_elapsed_time
    } mte_op_type;

    // one trippoint request from the sequencer
    typedef struct packed {
        mte_op_type              op;       // trippoint kind
        logic [MTE_AXIS_W-1:0]   axis;     // subject axis
        logic                    seq;      // subject is the coordinated sequence (speed wait only)
        logic [31:0]             operand;  // target, distance, speed or milliseconds
    } mte_cmd_type;

    // profiler state of one axis or of the coordinated sequence
    typedef struct packed {
        logic signed [31:0]      pos;      // commanded position, quadrature counts
        logic [31:0]             speed;    // generated profile speed
        logic [31:0]             slew;     // programmed slew speed
        logic                    dir_up;   // commanded motion toward larger counts
        logic                    running;  // profiler active
    } mte_axis_type;

    // evaluator states
    typedef enum logic [1:0] {
        MTE_IDLE,
        MTE_WAIT_POS,
        MTE_WAIT_SPEED,
        MTE_WAIT_TIME
    } mte_state_type;

endpackage

// [logic/mte_trippoint_evaluator.sv]
// trippoint evaluator: holds the sequencer until a position, distance, speed or time condition is met
// operation
// the sequencer offers one request with cmd_valid while hold_q is low
// waits met at issue answer with release_q one cycle later and never raise hold_q
// other waits raise hold_q one cycle after the request
// position and speed conditions are looked at only on the period tick
// time conditions are looked at every cycle
// release_q pulses for one cycle and hold_q falls on that same edge
// a request offered while a wait is pending is dropped without notice
//
// limitations
// the speed condition counts a pass over the request as reached
// S-curve profiles make the speed trip point land early or late
// the coordinated sequence may be the subject of speed waits only
module mte_trippoint_evaluator
    import mte_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = MTE_SAMPLE_CYCLES,   // cycles per evaluation period
    parameter int unsigned MS_CYCLES     = MTE_MS_CYCLES        // cycles per millisecond
)(
    input  wire logic                                   mclk,        // controller clock
    input  wire logic                                   rstn,        // asynchronous reset, active low
    input  wire logic                                   cmd_valid,   // one-cycle trippoint request
    input  wire mte_cmd_type                            cmd,         // trippoint request contents
    input  wire mte_axis_type [MTE_AXES-1:0]            axes,        // per-axis profiler state
    input  wire mte_axis_type                           seq,         // coordinated sequence profiler state
    output logic                                        hold_q,      // sequencer must not advance
    output logic                                        release_q,   // one-cycle pulse when a trippoint is met
    output logic [MTE_AXES-1:0][MTE_STAT_W-1:0]         status2_q    // second status word per axis
);

    // divider end values, sized to the counters
    // both must fit the 16-bit dividers; a faster clock needs wider counters
    localparam logic [MTE_DIV_W-1:0] SAMP_LAST = MTE_DIV_W'(SAMPLE_CYCLES - 1);
    localparam logic [MTE_DIV_W-1:0] MS_LAST   = MTE_DIV_W'(MS_CYCLES - 1);

    // sequencer side state
    mte_state_type                state_q;       // evaluator state
    mte_state_type                state_d;       // next evaluator state
    // dividers and millisecond time
    logic [MTE_DIV_W-1:0]         samp_cnt_q;    // evaluation period divider
    logic [MTE_DIV_W-1:0]         ms_cnt_q;      // millisecond divider
    logic [31:0]                  ms_now_q;      // free-running millisecond time
    // time wait operands
    logic [31:0]                  time_ref_q;    // reference for time waits
    logic [31:0]                  time_mag_q;    // milliseconds to wait
    logic                         time_adv_q;    // reference moves forward when met
    // position wait operands
    logic [MTE_AXIS_W-1:0]        axis_q;        // subject axis of the pending wait
    logic                         seq_q;         // speed wait watches the sequence
    logic                         rel_q;         // pending position wait is relative
    logic signed [31:0]           target_q;      // absolute crossing point
    logic                         ahead_q;       // target was above position at issue
    // speed wait operands
    logic [31:0]                  speed_q;       // requested speed
    logic                         below_q;       // speed was below request at issue
    // per-axis history
    logic signed [31:0]           move_ref_q [MTE_AXES];   // distance reference per axis
    logic [MTE_AXES-1:0]          run_prev_q;    // running seen last cycle

    // divider ticks
    // one-cycle enables; everything slower than mclk keys off these
    wire samp_tick = (samp_cnt_q == SAMP_LAST);
    wire ms_tick   = (ms_cnt_q == MS_LAST);

    // request side selection
    wire mte_axis_type      req_ax    = axes[cmd.axis];
    // distance mask
    // the top bit is dropped so a distance never reads as negative
    wire signed [31:0]      req_dist  = $signed(cmd.operand & MTE_DIST_MASK);
    wire signed [31:0]      req_ref   = move_ref_q[cmd.axis];
    // the relative target lies along the commanded direction
    wire signed [31:0]      rel_tgt   = req_ax.dir_up ? (req_ref + req_dist) : (req_ref - req_dist);
    wire signed [31:0]      req_tgt   = (cmd.op == MTE_OP_REL) ? rel_tgt : $signed(cmd.operand);
    wire mte_axis_type      req_spd   = cmd.seq ? seq : req_ax;
    // time operand split into sign and magnitude
    wire                    req_neg   = cmd.operand[31];
    wire [31:0]             req_mag   = req_neg ? (32'h0 - cmd.operand) : cmd.operand;
    // a request is taken only while idle; a strobe during a wait is dropped
    wire                    take      = cmd_valid && (state_q == MTE_IDLE);
    wire                    is_pos    = (cmd.op == MTE_OP_ABS) || (cmd.op == MTE_OP_REL);

    // pending side selection
    // cur and spd follow the captured subject, not the live request
    wire mte_axis_type      cur       = axes[axis_q];
    wire mte_axis_type      spd       = seq_q ? seq : cur;
    wire                    now_ahead = target_q > cur.pos;
    // a target met exactly counts as crossed
    wire                    crossed   = (cur.pos == target_q) || (now_ahead != ahead_q);
    // moving away
    // judged from the side recorded at issue, not from the sign of the error
    wire                    away      = ahead_q ? !cur.dir_up : cur.dir_up;
    // sampled check
    // crossing is judged only on the period tick, so the error is one period of travel
    wire                    pos_met   = samp_tick && (!cur.running || crossed || away);
    // either direction
    // the side recorded at issue decides whether reaching means rising to or falling to the speed
    wire                    spd_hit   = below_q ? (spd.speed >= speed_q) : (spd.speed <= speed_q);
    // stopped releases
    // a stop ends the wait whether or not the speed was reached
    wire                    spd_met   = samp_tick && (spd_hit || !spd.running);
    // elapsed compare
    // unsigned difference stays right across one wrap of the millisecond time
    wire [31:0]             elapsed   = ms_now_q - time_ref_q;
    // judged every cycle, not only on the period tick
    wire                    time_met  = elapsed >= time_mag_q;

    // immediate completions at issue
    // idle profiler met
    // a stopped axis would never cross, so the wait ends at issue
    wire                    pos_now   = take && is_pos && !req_ax.running;
    wire                    time_now  = take && (cmd.op == MTE_OP_TIME) && (cmd.operand == MTE_TIME_ZERO);

    // completion of a pending wait
    // each waiting state is judged only against its own kind
    wire                    met       = ((state_q == MTE_WAIT_POS) && pos_met)
                                     || ((state_q == MTE_WAIT_SPEED) && spd_met)
                                     || ((state_q == MTE_WAIT_TIME) && time_met);
    // both routes to completion drive the one release pulse
    wire                    done      = met || pos_now || time_now;
    // restart reference
    // only a real crossing moves the reference; a stop or reversal leaves it for the next move
    wire                    rel_cross = (state_q == MTE_WAIT_POS) && rel_q && samp_tick && cur.running && crossed;

    // next state
    always_comb begin
        // stay put unless a branch below moves on
        state_d = state_q;
        case (state_q)
            MTE_IDLE: begin
                // waits met at issue never leave idle
                if (take && !pos_now && !time_now) begin
                    case (cmd.op)
                        MTE_OP_ABS:   state_d = MTE_WAIT_POS;
                        MTE_OP_REL:   state_d = MTE_WAIT_POS;
                        MTE_OP_SPEED: state_d = MTE_WAIT_SPEED;
                        default:      state_d = MTE_WAIT_TIME;
                    endcase
                end
            end
            // release and clear
            // every waiting state leaves only through met
            default: begin
                if (met) begin
                    state_d = MTE_IDLE;
                end
            end
        endcase
    end

    // period and millisecond dividers with the millisecond time
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            // both dividers start a fresh period out of reset
            samp_cnt_q <= '0;
            ms_cnt_q   <= '0;
            ms_now_q   <= '0;
        end else begin
            samp_cnt_q <= samp_tick ? '0 : samp_cnt_q + 1'b1;
            ms_cnt_q   <= ms_tick ? '0 : ms_cnt_q + 1'b1;
            // the time wraps after 2**32 ms; the unsigned difference hides it
            if (ms_tick) begin
                ms_now_q <= ms_now_q + 32'h1;
            end
        end
    end

    // state, hold and release pulse
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            // no wait pending out of reset
            state_q   <= MTE_IDLE;
            hold_q    <= 1'b0;
            release_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            // hold follows the next state, so it falls on the edge that raises release
            hold_q    <= (state_d != MTE_IDLE);
            release_q <= done;
        end
    end

    // operands captured when a trippoint is taken
    // one wait is in flight at a time, so one set of registers serves every kind
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            // values are unread until the first take
            axis_q     <= '0;
            seq_q      <= 1'b0;
            rel_q      <= 1'b0;
            target_q   <= '0;
            ahead_q    <= 1'b0;
            speed_q    <= '0;
            below_q    <= 1'b0;
            time_mag_q <= '0;
            time_adv_q <= 1'b0;
        end else if (take) begin
            // single axis
            // the sequence flag is ignored for position waits; the axis field alone selects
            axis_q     <= cmd.axis;
            seq_q      <= cmd.seq && (cmd.op == MTE_OP_SPEED);
            rel_q      <= (cmd.op == MTE_OP_REL);
            target_q   <= req_tgt;
            ahead_q    <= req_tgt > req_ax.pos;
            // fields that do not fit the taken kind are stored and never read
            speed_q    <= cmd.operand;
            below_q    <= req_spd.speed < cmd.operand;
            time_mag_q <= req_mag;
            time_adv_q <= req_neg;
        end
    end

    // time reference
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            time_ref_q <= '0;
        // a zero wait takes the present time and is done at issue
        end else if (time_now) begin
            time_ref_q <= ms_now_q;
        // a positive wait leaves the reference where it was
        end else if ((state_q == MTE_WAIT_TIME) && time_met && time_adv_q) begin
            // advance reference
            // moves to the due instant, not the present time, so late releases do not drift
            time_ref_q <= time_ref_q + time_mag_q;
        end
    end

    // per-axis distance reference and status word
    // one copy of this logic per axis
    genvar gi;
    generate
        for (gi = 0; gi < MTE_AXES; gi++) begin : g_axis
            wire mte_axis_type ax    = axes[gi];
            // rise marks the first running cycle of a move
            wire               rise  = ax.running && !run_prev_q[gi];
            wire               adv   = rel_cross && (axis_q == MTE_AXIS_W'(gi));
            wire               slew  = ax.running && (ax.speed == ax.slew);

            // reference follows move start and relative crossings
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    run_prev_q[gi] <= 1'b0;
                    // references start at zero counts
                    move_ref_q[gi] <= '0;
                end else begin
                    run_prev_q[gi] <= ax.running;
                    // a crossing on this axis moves the reference to the exact trip point
                    if (adv) begin
                        move_ref_q[gi] <= target_q;
                    end else if (rise) begin
                        move_ref_q[gi] <= ax.pos;
                    end
                end
            end

            // status word refreshed each period
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    status2_q[gi] <= MTE_STAT_RST;
                end else if (samp_tick) begin
                    // slew flag
                    // spare bits return to their reset value each period
                    status2_q[gi]               <= MTE_STAT_RST;
                    status2_q[gi][MTE_SLEW_BIT] <= slew;
                end
            end
        end
    endgenerate

endmodule

// [sim/mte_trippoint_evaluator_assertions.sv]
// port checks for the trippoint evaluator
module mte_chk
    import mte_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = MTE_SAMPLE_CYCLES,  // cycles per period
    parameter int unsigned MS_CYCLES     = MTE_MS_CYCLES       // cycles per ms
)(
    input wire logic                                mclk,
    input wire logic                                rstn,
    input wire logic                                cmd_valid,
    input wire mte_cmd_type                         cmd,
    input wire mte_axis_type [MTE_AXES-1:0]         axes,
    input wire mte_axis_type                        seq,
    input wire logic                                hold_q,
    input wire logic                                release_q,
    input wire logic [MTE_AXES-1:0][MTE_STAT_W-1:0] status2_q
);
    timeunit 1ns;
    timeprecision 1ns;
    // a condition may sit one whole period before it is seen
    localparam int SMAX = SAMPLE_CYCLES + 3;
    mte_cmd_type      cap_q;                           // request now pending
    wire logic        take = cmd_valid && !hold_q;     // request offered while idle
    wire logic        pos_op = cap_q.op == MTE_OP_ABS || cap_q.op == MTE_OP_REL;
    wire logic        new_pos = cmd.op == MTE_OP_ABS || cmd.op == MTE_OP_REL;
    wire logic [31:0] subj_spd = cap_q.seq ? seq.speed : axes[cap_q.axis].speed;
    // keep the taken request so later checks know the subject
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cap_q <= '0;
        end else if (take) begin
            cap_q <= cmd;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_fall_rel; $fell(hold_q) |-> release_q; endproperty
    a_fall_rel: assert property (p_fall_rel) else $error("hold dropped without release");
    property p_pulse; release_q && !cmd_valid |=> !release_q; endproperty
    a_pulse: assert property (p_pulse) else $error("release longer than one cycle");
    property p_time0; take && cmd.op == MTE_OP_TIME && cmd.operand == MTE_TIME_ZERO |=> release_q && !hold_q; endproperty
    a_time0: assert property (p_time0) else $error("zero time wait not released");
    property p_idle; take && new_pos && !axes[cmd.axis].running |=> release_q && !hold_q; endproperty
    a_idle: assert property (p_idle) else $error("idle axis wait not released");
    property p_thold; take && cmd.op == MTE_OP_TIME && cmd.operand != MTE_TIME_ZERO |=> hold_q; endproperty
    a_thold: assert property (p_thold) else $error("timed wait did not hold");
    property p_stat; (status2_q & {MTE_AXES{8'hdf}}) == '0; endproperty
    a_stat: assert property (p_stat) else $error("status word spare bit set");
    property p_stop; hold_q && pos_op && !axes[cap_q.axis].running |-> ##[0:SMAX] release_q; endproperty
    a_stop: assert property (p_stop) else $error("stopped axis wait not released");
    property p_speed; hold_q && cap_q.op == MTE_OP_SPEED && subj_spd == cap_q.operand |-> ##[0:SMAX] release_q; endproperty
    a_speed: assert property (p_speed) else $error("speed reached but wait held");
endmodule

// [sim/mte_profiler_model.sv]
// behavioural axis profiler facing the evaluator
module mte_profiler_model
    import mte_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic [MTE_AXES-1:0]    run,    // profiler active per axis
    input  wire logic [MTE_AXES-1:0]    up,     // motion toward larger counts
    input  wire logic                   load,   // preset every position
    input  wire logic [31:0]            start,  // preset value
    input  wire logic [31:0]            step,   // counts per cycle
    input  wire logic [31:0]            goal,   // slew speed of all axes
    output mte_axis_type [MTE_AXES-1:0] axes,
    output mte_axis_type                seq
);
    timeunit 1ns;
    timeprecision 1ns;
    // the sequence mirrors axis 0, so a wrong subject shows
    assign seq = axes[0];
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            axes <= '0;
        end else begin
            for (int i = 0; i < MTE_AXES; i++) begin
                axes[i].running <= run[i];
                axes[i].dir_up  <= up[i];
                axes[i].slew    <= goal;
                axes[i].pos     <= load ? $signed(start) : !run[i] ? axes[i].pos :
                                   up[i] ? axes[i].pos + $signed(step) : axes[i].pos - $signed(step);
                // a stop drops speed at once, which is harsher than a real ramp down
                axes[i].speed   <= !run[i] ? 32'h0 : axes[i].speed < goal ? axes[i].speed + 32'h1 :
                                   axes[i].speed > goal ? axes[i].speed - 32'h1 : axes[i].speed;
            end
        end
    end
endmodule

// [sim/tb_top.sv]
// directed bench for the trippoint evaluator
module tb_top
    import mte_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 20;                            // shortened period
    localparam int MS = 10;                            // shortened millisecond
    localparam int PW = 5 * (SC + 3);                  // worst overshoot at step 5
    logic mclk, rstn, cmd_valid, hold_q, release_q, load;
    mte_cmd_type cmd;
    mte_axis_type [MTE_AXES-1:0] axes;
    mte_axis_type seq;
    logic [MTE_AXES-1:0][MTE_STAT_W-1:0] status2_q;
    logic [MTE_AXES-1:0] run, up;
    logic [31:0] start, step, goal;
    int mismatches = 0, n_checks = 0, n = 0, cyc = 0, t0;
    mte_trippoint_evaluator #(.SAMPLE_CYCLES(SC), .MS_CYCLES(MS)) DUT (.mclk(mclk), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd(cmd), .axes(axes), .seq(seq), .hold_q(hold_q),
        .release_q(release_q), .status2_q(status2_q));
    mte_profiler_model u_prof (.mclk(mclk), .rstn(rstn), .run(run), .up(up), .load(load),
        .start(start), .step(step), .goal(goal), .axes(axes), .seq(seq));
    // free cycle count for elapsed-time windows
    always @(posedge mclk) cyc++;
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one axis per request, one-cycle strobe, bounded wait for release
    task automatic go(input mte_op_type op, input logic [1:0] ax, input logic sq, input logic [31:0] v);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd = '{op: op, axis: ax, seq: sq, operand: v};
        @(negedge mclk);
        cmd_valid = 1'b0;
        n = 0;
        while (release_q !== 1'b1) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 4000) begin
                check("release wait", 0, 1);
                end_sim();
            end
        end
    endtask
    // preset positions, then start the chosen axes
    task automatic prof(input logic [3:0] r, input logic [3:0] u, input logic [31:0] s, input logic [31:0] st);
        @(negedge mclk);
        {run, up, load, start, step} = {4'h0, u, 1'b1, s, st};
        @(negedge mclk);
        {run, load} = {r, 1'b0};
    endtask
    task automatic t_time();
        go(MTE_OP_TIME, 2'd0, 1'b0, MTE_TIME_ZERO);
        check("zero wait", n, 0);
        t0 = cyc;
        go(MTE_OP_TIME, 2'd0, 1'b0, 32'd3);
        check("3 ms", cyc - t0 >= 2 * MS && cyc - t0 <= 3 * MS + 3, 1);
        go(MTE_OP_TIME, 2'd0, 1'b0, 32'hfffffffc);
        check("-4 ms", cyc - t0 >= 3 * MS && cyc - t0 <= 4 * MS + 3, 1);
        go(MTE_OP_TIME, 2'd0, 1'b0, 32'd2);
        check("2 ms new ref", cyc - t0 >= 5 * MS && cyc - t0 <= 6 * MS + 3, 1);
    endtask
    task automatic t_pos();
        go(MTE_OP_ABS, 2'd2, 1'b0, 32'd50);
        check("idle abs", n, 0);
        go(MTE_OP_REL, 2'd2, 1'b0, 32'd50);
        check("idle rel", n, 0);
        prof(4'b0010, 4'b0010, 32'd0, 32'd5);
        go(MTE_OP_ABS, 2'd1, 1'b0, 32'd1000);
        check("abs up", axes[1].pos >= 1000 && axes[1].pos < 1000 + PW, 1);
        prof(4'b0010, 4'b0000, 32'h800003e8, 32'd5);
        go(MTE_OP_ABS, 2'd1, 1'b0, 32'h800000c8);
        check("abs low", axes[1].pos - $signed(32'h800000c8) inside {[-PW:0]}, 1);
        go(MTE_OP_ABS, 2'd1, 1'b0, 32'h800003e8);
        check("away", n > 0 && n <= SC, 1);
        prof(4'b0010, 4'b0010, 32'd0, 32'd1);
        fork
            go(MTE_OP_ABS, 2'd1, 1'b0, 32'd100000);
            begin
                repeat (30) @(negedge mclk);
                run = 4'h0;
            end
        join
        check("stop", n >= 30 && n <= 30 + SC + 4, 1);
    endtask
    task automatic t_rel();
        prof(4'b1000, 4'b1000, 32'd0, 32'd5);
        go(MTE_OP_REL, 2'd3, 1'b0, 32'd400);
        check("rel 1", axes[3].pos >= 400 && axes[3].pos < 400 + PW, 1);
        go(MTE_OP_REL, 2'd3, 1'b0, 32'd400);
        check("rel 2", axes[3].pos >= 800 && axes[3].pos < 805 + PW, 1);
        go(MTE_OP_REL, 2'd3, 1'b0, 32'h800000c8);
        check("rel masked", axes[3].pos >= 1000 && axes[3].pos < 1010 + PW, 1);
    endtask
    task automatic t_speed();
        prof(4'b0001, 4'b0001, 32'd0, 32'd1);
        go(MTE_OP_SPEED, 2'd0, 1'b0, 32'd150);
        check("accel", axes[0].speed >= 150 && axes[0].speed < 150 + SC + 3, 1);
        @(negedge mclk) goal = 32'd50;
        go(MTE_OP_SPEED, 2'd0, 1'b0, 32'd100);
        check("decel", axes[0].speed <= 100 && axes[0].speed > 100 - SC - 3, 1);
        @(negedge mclk) goal = 32'd300;
        go(MTE_OP_SPEED, 2'd3, 1'b1, 32'd200);
        check("sequence", n > 1 && seq.speed >= 200, 1);
        fork
            go(MTE_OP_SPEED, 2'd0, 1'b0, 32'd1000);
            begin
                repeat (300) @(negedge mclk);
                check("slew flag", status2_q[0], 8'h20);
                check("other flag", status2_q[1], 8'h00);
                run = 4'h0;
            end
        join
        check("never reached", n >= 300 && n <= 300 + SC + 4, 1);
    endtask
    initial begin
        {rstn, cmd_valid, cmd, run, up, load, start, step, goal} = '0;
        goal = 32'd300;
        repeat (16) @(negedge mclk);
        rstn = 1'b1;
        check("status reset", status2_q[0], MTE_STAT_RST);
        check("hold reset", hold_q, 0);
        check("release reset", release_q, 0);
        t_time();
        t_pos();
        t_rel();
        t_speed();
        end_sim();
    end
endmodule
// checker rides on every evaluator instance
bind mte_trippoint_evaluator mte_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .MS_CYCLES(MS_CYCLES)) u_chk (
    .mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd), .axes(axes), .seq(seq),
    .hold_q(hold_q), .release_q(release_q), .status2_q(status2_q));
